// ### sample_buffer.sv
// Two-entry buffer carrying converter samples into the readout.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module sample_buffer #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [PTR_W-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [PTR_W:0]   cnt_r, cnt_nxt;
  logic [WIDTH-1:0] dout_r, dout_nxt;
  logic             push, pop;

  assign in_ready_o  = (cnt_r != (PTR_W+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = dout_r;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    mem_nxt = mem_r;
    wr_nxt  = wr_r;
    rd_nxt  = rd_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wr_r] = in_data_i;
      wr_nxt = (wr_r == PTR_W'(DEPTH-1)) ? '0 : wr_r + 1'b1;
    end
    if (pop) begin
      rd_nxt = (rd_r == PTR_W'(DEPTH-1)) ? '0 : rd_r + 1'b1;
    end
    cnt_nxt = cnt_r + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    // Registered head: shows the entry that will be at the read pointer
    if (cnt_nxt == '0) begin
      dout_nxt = '0;
    end else begin
      dout_nxt = mem_nxt[rd_nxt];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_r   <= '0;
      rd_r   <= '0;
      cnt_r  <= '0;
      dout_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      wr_r   <= wr_nxt;
      rd_r   <= rd_nxt;
      cnt_r  <= cnt_nxt;
      dout_r <= dout_nxt;
      mem_r  <= mem_nxt;
    end
  end
endmodule // sample_buffer
`default_nettype wire

// ### sar_readout_pkg.sv
// Package for the serial converter readout: widths, counts, phase states.
// Assumes the host clocks the link far slower than clk_i (80 ns link period).
package sar_readout_pkg;
  localparam int unsigned RES_BITS       = 12;
  localparam int unsigned CNT_W          = 5;
  localparam logic [11:0] CODE_MIN       = 12'h000;
  localparam logic [11:0] CODE_MAX       = 12'hfff;
  localparam int unsigned FULL_SCALE     = 4096;
  localparam int unsigned BUF_DEPTH      = 2;
  localparam logic [4:0]  MSB_LAST_FALL  = 5'h0e;
  localparam logic [4:0]  LSB_LAST_FALL  = 5'h19;
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned HOLD_LIMIT_US  = 1200;
  localparam int unsigned HOLD_LIMIT_CYC = HOLD_LIMIT_US * 1000 / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    PH_STANDBY,
    PH_ACQUIRE,
    PH_NULL,
    PH_MSB_FIRST,
    PH_LSB_FIRST,
    PH_ZEROS
  } phase_t;
endpackage

// ### serial_sar_adc_readout.sv
// Serial readout and conversion sequencing of a 12-bit SAR converter.
// Assumes the host's chip select and serial clock are asynchronous pins,
// and that the analog side delivers settled codes over a valid/ready port.
//
// Notes on behaviour
// - Select low starts session, high ends it
// - Acquire 1.5 clocks from first rise
// - Then hold input, one bit per clock
// - Output floats for first two clocks
// - Second falling edge drives low null bit
// - Next twelve falls give result MSB first
// - MSB appears at third falling edge
// - Output changes on falling edges only
// - Further clocks repeat result LSB first
// - LSB sequence shares final bit, then bit one
// - Afterwards zeros forever while selected
// - Tolerate varying clock period and duty
// - Result is 4096 times input over reference
// - Result clamps at 000h and fff
`timescale 1ns/10ps
`default_nettype none
module serial_sar_adc_readout (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        chip_select_shutdown_n_i,
  input  wire logic        sclk_i,
  output logic             dout_o,
  output logic             dout_oe_o,
  input  wire logic        code_valid_i,
  output logic             code_ready_o,
  input  wire logic [11:0] code_i,
  input  wire logic        code_below_i,
  input  wire logic        code_above_i,
  output logic             sample_capacitor_track_o,
  output logic             converting_o,
  output logic             standby_o
);
  localparam int unsigned W = sar_readout_pkg::RES_BITS;

  // Two-stage synchronisers for the asynchronous pins
  logic cs_meta_r, cs_sync_r, cs_prev_r;
  logic ck_meta_r, ck_sync_r, ck_prev_r;
  logic cs_meta_nxt, cs_sync_nxt, cs_prev_nxt;
  logic ck_meta_nxt, ck_sync_nxt, ck_prev_nxt;
  logic ck_rise, ck_fall, cs_fall, selected;

  always_comb begin
    cs_meta_nxt = chip_select_shutdown_n_i;
    cs_sync_nxt = cs_meta_r;
    cs_prev_nxt = cs_sync_r;
    ck_meta_nxt = sclk_i;
    ck_sync_nxt = ck_meta_r;
    ck_prev_nxt = ck_sync_r;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      // Select taken as low at reset: only a real high on the pin arms a session
      cs_meta_r <= 1'b0;
      cs_sync_r <= 1'b0;
      cs_prev_r <= 1'b0;
      ck_meta_r <= 1'b0;
      ck_sync_r <= 1'b0;
      ck_prev_r <= 1'b0;
    end else begin
      cs_meta_r <= cs_meta_nxt;
      cs_sync_r <= cs_sync_nxt;
      cs_prev_r <= cs_prev_nxt;
      ck_meta_r <= ck_meta_nxt;
      ck_sync_r <= ck_sync_nxt;
      ck_prev_r <= ck_prev_nxt;
    end
  end

  assign selected = !cs_sync_r;
  assign cs_fall  = cs_prev_r && !cs_sync_r;
  assign ck_rise  = selected && ck_sync_r && !ck_prev_r;
  assign ck_fall  = selected && !ck_sync_r && ck_prev_r;

  // Armed only after select has been seen high since reset
  logic armed_r, armed_nxt;

  // Code arrives through a small buffer so a late readout loses no sample
  logic          buf_valid, buf_ready, buf_in_ready;
  logic [W-1:0]  buf_data;
  logic [W-1:0]  clamped;

  always_comb begin
    clamped = code_i;
    if (code_below_i) begin
      clamped = sar_readout_pkg::CODE_MIN;
    end else if (code_above_i) begin
      clamped = sar_readout_pkg::CODE_MAX;
    end
  end

  assign code_ready_o = buf_in_ready;

  sample_buffer #(
    .WIDTH (W),
    .DEPTH (sar_readout_pkg::BUF_DEPTH)
  ) u_sample_buffer (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (code_valid_i),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (clamped),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_ready),
    .out_data_o  (buf_data)
  );

  sar_readout_pkg::phase_t phase_r, phase_nxt;
  logic [sar_readout_pkg::CNT_W-1:0] fall_cnt_r, fall_cnt_nxt;
  logic [W-1:0] result_r, result_nxt;
  logic         dout_r, dout_nxt;
  logic         oe_r, oe_nxt;
  logic         track_r, track_nxt;
  logic [3:0]   idx;
  logic [sar_readout_pkg::CNT_W-1:0] fall_pos;

  // Number of the coming fall, taken from the register to avoid a comb loop
  assign fall_pos = fall_cnt_r + 1'b1;

  // Bit index within the result for the current falling edge
  always_comb begin
    idx = '0;
    if (fall_pos <= sar_readout_pkg::MSB_LAST_FALL) begin
      idx = 4'(sar_readout_pkg::MSB_LAST_FALL - fall_pos);
    end else begin
      idx = 4'(fall_pos - sar_readout_pkg::MSB_LAST_FALL);
    end
  end

  // Result taken when acquisition closes; code read from buffer head
  assign buf_ready = ck_fall && (phase_r == sar_readout_pkg::PH_ACQUIRE) && (fall_cnt_r != '0);

  always_comb begin
    armed_nxt    = armed_r;
    phase_nxt    = phase_r;
    fall_cnt_nxt = fall_cnt_r;
    result_nxt   = result_r;
    dout_nxt     = dout_r;
    oe_nxt       = oe_r;
    track_nxt    = track_r;
    if (!selected) begin
      armed_nxt    = 1'b1;
      phase_nxt    = sar_readout_pkg::PH_STANDBY;
      fall_cnt_nxt = '0;
      oe_nxt       = 1'b0;
      dout_nxt     = 1'b0;
      track_nxt    = 1'b0;
    end else begin
      unique case (phase_r)
        sar_readout_pkg::PH_STANDBY: begin
          if (armed_r && cs_fall) begin
            phase_nxt = sar_readout_pkg::PH_ACQUIRE;
          end
        end
        sar_readout_pkg::PH_ACQUIRE: begin
          if (ck_rise && !track_r) begin
            track_nxt = 1'b1;
          end
          if (ck_fall && track_r) begin
            fall_cnt_nxt = fall_cnt_r + 1'b1;
            if (fall_cnt_r != '0) begin
              // Second fall: hold the charge, drive null bit
              track_nxt  = 1'b0;
              result_nxt = buf_valid ? buf_data : result_r;
              phase_nxt  = sar_readout_pkg::PH_NULL;
              oe_nxt     = 1'b1;
              dout_nxt   = 1'b0;
            end
          end
        end
        sar_readout_pkg::PH_NULL,
        sar_readout_pkg::PH_MSB_FIRST,
        sar_readout_pkg::PH_LSB_FIRST: begin
          // Only falling edges move the output; rises are ignored
          if (ck_fall) begin
            fall_cnt_nxt = fall_cnt_r + 1'b1;
            dout_nxt     = result_r[idx];
            if (fall_cnt_nxt == sar_readout_pkg::MSB_LAST_FALL) begin
              phase_nxt = sar_readout_pkg::PH_LSB_FIRST;
            end else if (fall_cnt_nxt > sar_readout_pkg::LSB_LAST_FALL) begin
              phase_nxt = sar_readout_pkg::PH_ZEROS;
              dout_nxt  = 1'b0;
            end else if (phase_r == sar_readout_pkg::PH_NULL) begin
              phase_nxt = sar_readout_pkg::PH_MSB_FIRST;
            end
          end
        end
        sar_readout_pkg::PH_ZEROS: begin
          if (ck_fall) begin
            dout_nxt = 1'b0;
          end
        end
        default: begin
          phase_nxt = sar_readout_pkg::PH_STANDBY;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      armed_r    <= 1'b0;
      phase_r    <= sar_readout_pkg::PH_STANDBY;
      fall_cnt_r <= '0;
      result_r   <= '0;
      dout_r     <= 1'b0;
      oe_r       <= 1'b0;
      track_r    <= 1'b0;
    end else begin
      armed_r    <= armed_nxt;
      phase_r    <= phase_nxt;
      fall_cnt_r <= fall_cnt_nxt;
      result_r   <= result_nxt;
      dout_r     <= dout_nxt;
      oe_r       <= oe_nxt;
      track_r    <= track_nxt;
    end
  end

  assign dout_o                   = dout_r;
  assign dout_oe_o                = oe_r;
  assign sample_capacitor_track_o = track_r;
  assign converting_o             = (phase_r == sar_readout_pkg::PH_NULL) ||
                                    (phase_r == sar_readout_pkg::PH_MSB_FIRST);
  assign standby_o                = (phase_r == sar_readout_pkg::PH_STANDBY);
endmodule // serial_sar_adc_readout
`default_nettype wire

// ### serial_sar_adc_readout_asserts.sv
// Port timing checks for the serial converter readout.
// Assumes 40 ns link halves in the first two clocks and no mid-frame select glitches.
`timescale 1ns/10ps
`default_nettype none
module serial_sar_adc_readout_asserts (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic chip_select_shutdown_n_i,
  input wire logic sclk_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  input wire logic code_ready_o,
  input wire logic sample_capacitor_track_o,
  input wire logic converting_o,
  input wire logic standby_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_deselected; chip_select_shutdown_n_i [*6]; endsequence
  // Two link clocks are 20 cycles; acquisition spans 1.5 of them
  sequence s_track_win; sample_capacitor_track_o [*8] ##[6:9] !sample_capacitor_track_o; endsequence
  property p_idle_float; s_deselected |-> !dout_oe_o && standby_o; endproperty
  a_idle_float: assert property (p_idle_float) else $error("driven while deselected");
  property p_wake; $fell(chip_select_shutdown_n_i) |-> ##[2:5] !standby_o; endproperty
  a_wake: assert property (p_wake) else $error("no wake on select");
  property p_track_len; $rose(sample_capacitor_track_o) |-> s_track_win; endproperty
  a_track_len: assert property (p_track_len) else $error("acquire length off");
  property p_null_bit;
    $rose(dout_oe_o) |-> !dout_o && converting_o && !sample_capacitor_track_o;
  endproperty
  a_null_bit: assert property (p_null_bit) else $error("bad null bit");
  property p_rise_quiet; $rose(sclk_i) && dout_oe_o |=> $stable(dout_o) [*6]; endproperty
  a_rise_quiet: assert property (p_rise_quiet) else $error("data moved on rise");
  property p_conv_len; $rose(converting_o) |-> converting_o [*8]; endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion cut short");
  property p_standby_clear;
    standby_o |-> !converting_o && !sample_capacitor_track_o && !dout_oe_o;
  endproperty
  a_standby_clear: assert property (p_standby_clear) else $error("active in standby");
  property p_ready_pop; $rose(code_ready_o) |-> converting_o; endproperty
  a_ready_pop: assert property (p_ready_pop) else $error("buffer freed off session");
endmodule // serial_sar_adc_readout_asserts
bind serial_sar_adc_readout serial_sar_adc_readout_asserts u_asserts (
  .clk_i(clk_i), .srst_i(srst_i), .chip_select_shutdown_n_i(chip_select_shutdown_n_i),
  .sclk_i(sclk_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o), .code_ready_o(code_ready_o),
  .sample_capacitor_track_o(sample_capacitor_track_o), .converting_o(converting_o),
  .standby_o(standby_o));
`default_nettype wire

// ### serial_sar_adc_readout_tb_top.sv
// Self-checking bench for the serial converter readout.
// Assumes the host model for the link side and drives the code port itself.
`timescale 1ns/10ps
`default_nettype none
module serial_sar_adc_readout_tb_top;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        code_valid_i = 1'b0;
  logic        code_below_i = 1'b0;
  logic        code_above_i = 1'b0;
  logic [11:0] code_i = 12'h000;
  logic        cs_n, sclk, dout, dout_oe, code_ready_o, track, converting, standby;
  logic [31:0] host_rx, host_en;
  int          compares = 0;
  int          fail_count = 0;
  always #4 clk_i = ~clk_i;
  serial_sar_adc_readout dut (.clk_i(clk_i), .srst_i(srst_i),
    .chip_select_shutdown_n_i(cs_n), .sclk_i(sclk), .dout_o(dout), .dout_oe_o(dout_oe),
    .code_valid_i(code_valid_i), .code_ready_o(code_ready_o), .code_i(code_i),
    .code_below_i(code_below_i), .code_above_i(code_above_i),
    .sample_capacitor_track_o(track), .converting_o(converting), .standby_o(standby));
  spi_host_model host (.clk_i(clk_i), .dout_i(dout), .dout_oe_i(dout_oe),
    .chip_select_shutdown_n_o(cs_n), .sclk_o(sclk), .rx_o(host_rx), .en_o(host_en));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic push(input logic [11:0] c, input logic below, input logic above);
    code_valid_i = 1'b1;
    code_i = c;
    code_below_i = below;
    code_above_i = above;
    for (int t = 0; code_ready_o !== 1'b1; t++) begin
      if (t == 50) begin
        fail_count++;
        test_done();
      end
      @(negedge clk_i);
    end
    @(negedge clk_i);
    code_valid_i = 1'b0;
  endtask
  task automatic run(input int n, input bit idle_hi, input int slow, input logic [11:0] c);
    logic [31:0] d, e;
    d = 32'h0;
    e = 32'h0;
    for (int i = 3; i <= n; i++) begin
      e[i-1] = 1'b1;
      if (i >= 4 && i <= 15) d[i-1] = c[15-i];
      else if (i >= 16 && i <= 26) d[i-1] = c[i-15];
    end
    host.session(n, idle_hi, slow);
    check("data", host_rx, d);
    check("enable", host_en, e);
    repeat (6) @(negedge clk_i);
    check("standby", {31'h0, standby}, 32'h1);
    check("float", {31'h0, dout_oe}, 32'h0);
  endtask
  task automatic t_powerup;
    host.pulses(8, 1'b0, 0);
    check("no session", host_en, 32'h0);
    $display("test powerup done");
  endtask
  task automatic t_modes;
    logic [7:0] hi, lo;
    push(12'ha5c, 1'b0, 1'b0);
    run(32, 1'b0, 0, 12'ha5c);
    push(12'h3c1, 1'b0, 1'b0);
    run(16, 1'b1, 3, 12'h3c1);
    for (int i = 0; i < 8; i++) begin
      hi[7-i] = host_rx[i];
      lo[7-i] = host_rx[8+i];
    end
    lo = {hi[0], lo[7:1]};
    hi = hi >> 1;
    check("realigned", {20'h0, hi[3:0], lo}, 32'h3c1);
    $display("test modes done");
  endtask
  task automatic t_clamp;
    logic [11:0] want [3] = '{12'h000, 12'hfff, 12'h000};
    for (int k = 0; k < 3; k++) begin
      push(12'h5a5, k != 1, k != 0);
      run(16, 1'b0, 0, want[k]);
    end
    $display("test clamp done");
  endtask
  // Bench offers a third code while the buffer is full; it is refused and withdrawn, so 456h is read again
  task automatic t_buffer;
    push(12'h123, 1'b0, 1'b0);
    push(12'h456, 1'b0, 1'b0);
    check("ready full", {31'h0, code_ready_o}, 32'h0);
    code_valid_i = 1'b1;
    code_i = 12'h789;
    repeat (3) @(negedge clk_i);
    code_valid_i = 1'b0;
    run(16, 1'b0, 0, 12'h123);
    run(16, 1'b1, 0, 12'h456);
    run(16, 1'b0, 0, 12'h456);
    $display("test buffer done");
  endtask
  task automatic t_abort;
    push(12'h6b2, 1'b0, 1'b0);
    host.session(9, 1'b0, 0);
    push(12'h19e, 1'b0, 1'b0);
    run(16, 1'b0, 0, 12'h19e);
    $display("test abort done");
  endtask
  initial begin
    repeat (10) @(negedge clk_i);
    srst_i = 1'b0;
    t_powerup();
    t_modes();
    t_clamp();
    t_buffer();
    t_abort();
    test_done();
  end
endmodule // serial_sar_adc_readout_tb_top
`default_nettype wire

// ### spi_host_model.sv
// Behavioural serial host: drives select and link clock, samples data on rises.
// Assumes it is called at clk_i falling edges; a link half is five clk_i periods, plus slow on odd low halves after the second pulse.
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  input  wire logic        clk_i,
  input  wire logic        dout_i,
  input  wire logic        dout_oe_i,
  output logic             chip_select_shutdown_n_o,
  output logic             sclk_o,
  output logic [31:0]      rx_o,
  output logic [31:0]      en_o
);
  // Select low from power-up: the device must ignore it
  initial begin
    chip_select_shutdown_n_o = 1'b0;
    sclk_o = 1'b0;
    rx_o = 32'h0;
    en_o = 32'h0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // A floating output is recorded as 0 with its enable bit low
  task automatic pulses(input int n, input bit idle_hi, input int slow);
    for (int i = 0; i < n; i++) begin
      int lo;
      lo = 5 + ((i > 1) ? slow * (i % 2) : 0);
      if (idle_hi) begin
        sclk_o = 1'b0;
        wait_clk(lo);
      end
      sclk_o = 1'b1;
      rx_o[i] = dout_oe_i & dout_i;
      en_o[i] = dout_oe_i;
      wait_clk(5);
      if (!idle_hi) begin
        sclk_o = 1'b0;
        wait_clk(lo);
      end
    end
  endtask
  task automatic session(input int n, input bit idle_hi, input int slow);
    chip_select_shutdown_n_o = 1'b1;
    sclk_o = idle_hi;
    rx_o = 32'h0;
    en_o = 32'h0;
    wait_clk(10);
    chip_select_shutdown_n_o = 1'b0;
    wait_clk(5);
    pulses(n, idle_hi, slow);
    wait_clk(5);
    chip_select_shutdown_n_o = 1'b1;
  endtask
endmodule // spi_host_model
`default_nettype wire
